// [logic/pan_consts.vh]
`ifndef PAN_CONSTS_VH
`define PAN_CONSTS_VH

// Register indices on the management bus.
`define PAN_REG_ID_LOW      5'h02
`define PAN_REG_ID_HIGH     5'h03
`define PAN_REG_ADVERTISE   5'h04
`define PAN_REG_PARTNER     5'h05

// Advertisement register field positions.
`define PAN_ADV_NEXT_PAGE   15
`define PAN_ADV_LOCAL_FAULT 13
`define PAN_ADV_T4          9
`define PAN_ADV_TX_FULL     8
`define PAN_ADV_TX_HALF     7
`define PAN_ADV_T_FULL      6
`define PAN_ADV_T_HALF      5

// Advertisement reset value, writable bits and bits forced to one.
`define PAN_ADV_RESET       16'h01E1
`define PAN_ADV_WR_MASK     16'hA1E0
`define PAN_ADV_FIXED       16'h0001

// Partner page bits kept; acknowledge, reserved and T4 read as zero.
`define PAN_LP_KEEP_MASK    16'hA1FF
`define PAN_LP_RESET        16'h0000

// Identifier register field positions.
`define PAN_ID_ORG_LSB      10
`define PAN_ID_MODEL_LSB    4
`define PAN_ID_REV_LSB      0

// Serial frame layout and timing counts, in management clock bits.
`define PAN_PREAMBLE_BITS   6'h20
`define PAN_HDR_LAST        4'hC
`define PAN_DATA_BITS       5'h10
`define PAN_OP_READ         2'h2
`define PAN_OP_WRITE        2'h1

`endif

// [logic/pan_sync.v]
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for the management pins, with a rising edge
// detector on bit 0 that looks only at the settled second stage.
module pan_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk,     // System clock.
  input  wire             rst,     // Asynchronous reset, active high.
  input  wire [WIDTH-1:0] async_in, // Pins from outside the clock domain.
  output wire [WIDTH-1:0] sync_out, // Settled copies of the pins.
  output reg              rise_r   // One-cycle pulse on a rise of bit 0.
);

  reg             prev_r;  // Delayed bit 0 for edge detection.

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_r;  // First stage, read only by the second.
      reg stab_r;  // Second stage, safe for logic.
      // Each pin gets its own pair of flops, so every flop has one driver.
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_r <= 1'b0;
          stab_r <= 1'b0;
        end else begin
          meta_r <= async_in[gi];
          stab_r <= meta_r;
        end
      end
      assign sync_out[gi] = stab_r;
    end
  endgenerate

  // Edge detection works on the settled stage so metastability cannot leak.
  // The reset level of zero matches the idle-low clock, so no false edge.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      prev_r <= sync_out[0];
      rise_r <= sync_out[0] & ~prev_r;
    end
  end

endmodule // pan_sync

`default_nettype wire

// [logic/pan_regs.v]
// Overview of operation
// - Second identifier returns fixed organization, model, revision.
// - Advertisement bit 15 next page, resets zero.
// - Advertisement bit 13 local fault, resets zero.
// - Advertisement bits 8, 6 full duplex, reset one.
// - Advertisement selector always reads 802.3 value.
// - T4 ability bit always reads zero.
// - Partner bits 8 to 5 read-only, reset zero.
// - Partner selector bits 4 to 0 read-only.
`timescale 1ns/1ps
`default_nettype none
`include "pan_consts.vh"

module pan_regs #(
  parameter [4:0]  PHY_ADDR   = 5'h01,   // Bus address this device answers.
  parameter [15:0] ID_LOW_VAL = 16'h1234, // Arbitrary value.
  parameter [5:0]  ORG_BITS   = 6'h2A,   // Arbitrary value.
  parameter [5:0]  MODEL_NUM  = 6'h11,   // Arbitrary value.
  parameter [3:0]  REV_NUM    = 4'h3     // Arbitrary value.
) (
  input  wire        clk,           // System clock, 40 MHz.
  input  wire        rst,           // Asynchronous reset, active high.
  input  wire        mgmt_clk,      // Management clock pin.
  input  wire        mgmt_data_in,  // Management data pin, input side.
  output reg         mgmt_data_out, // Management data pin, output side.
  output reg         mgmt_data_oe,  // High while the device drives data.
  output reg  [15:0] adv_page,      // Base page offered to the partner.
  input  wire [15:0] lp_page,       // Base page received from the partner.
  input  wire        lp_page_valid  // One-cycle strobe for lp_page.
);

  // Frame states.
  localparam [2:0] S_PRE = 3'h0;  // Counting preamble ones.
  localparam [2:0] S_HDR = 3'h1;  // Collecting start, opcode and addresses.
  localparam [2:0] S_TA  = 3'h2;  // Turnaround bits.
  localparam [2:0] S_RD  = 3'h3;  // Shifting read data out.
  localparam [2:0] S_WR  = 3'h4;  // Shifting write data in.

  wire [1:0]  pin_s;        // Synchronised pins: bit 0 clock, bit 1 data.
  wire        mdc_rise;     // Rising edge of the management clock.
  wire        bit_in;       // Sampled data bit.
  wire [12:0] hdr_word;     // Header including the bit sampled now.

  reg  [2:0]  state_r;      // Frame state.
  reg  [5:0]  pre_cnt_r;    // Saturating count of preamble ones.
  reg  [4:0]  bit_cnt_r;    // Bit counter within a field.
  reg  [11:0] hdr_r;        // Header shift register.
  reg  [4:0]  reg_sel_r;    // Register index of the frame.
  reg         is_read_r;    // Frame is a read.
  reg  [15:0] shift_r;      // Data shift register, either direction.
  reg  [15:0] lp_r;         // Partner ability register.
  reg  [15:0] rd_data;      // Read data for the addressed register.
  wire [15:0] id_high;      // Second identifier contents.

  // Both pins cross into the system clock together so data stays aligned.
  pan_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({mgmt_data_in, mgmt_clk}),
    .sync_out (pin_s),
    .rise_r   (mdc_rise)
  );

  assign bit_in   = pin_s[1];
  assign hdr_word = {hdr_r, bit_in};

  // The second identifier is built from fixed fields only.
  assign id_high = {ORG_BITS, MODEL_NUM, REV_NUM};

  // Read multiplexer; unmapped indices read as zero.
  always @* begin
    case (reg_sel_r)
      `PAN_REG_ID_LOW:    rd_data = ID_LOW_VAL;
      `PAN_REG_ID_HIGH:   rd_data = id_high;
      `PAN_REG_ADVERTISE: rd_data = adv_page;
      `PAN_REG_PARTNER:   rd_data = lp_r;
      default:            rd_data = 16'h0000;
    endcase
  end

  // Opcode decode shared by the read flag and the frame check.
  function op_is_read;
    input [1:0] op; // Opcode field of the header.
    begin
      op_is_read = (op == `PAN_OP_READ);
    end
  endfunction

  // Serial frame engine. All decisions are made on a rising management
  // clock edge, so the data seen is the bit the controller set up before
  // it. Output changes land a few system clocks after that edge, well
  // inside the controller's sampling window at any legal bus rate.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r       <= S_PRE;
      pre_cnt_r     <= 6'h00;
      bit_cnt_r     <= 5'h00;
      hdr_r         <= 12'h000;
      reg_sel_r     <= 5'h00;
      is_read_r     <= 1'b0;
      shift_r       <= 16'h0000;
      mgmt_data_out <= 1'b0;
      mgmt_data_oe  <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        S_PRE: begin
          // A full preamble is needed before every frame; no suppression.
          if (bit_in) begin
            // Saturate so a long run of ones still counts as one preamble.
            if (pre_cnt_r != `PAN_PREAMBLE_BITS) begin
              pre_cnt_r <= pre_cnt_r + 6'h01;
            end
          end else if (pre_cnt_r == `PAN_PREAMBLE_BITS) begin
            // First start bit seen.
            state_r   <= S_HDR;
            bit_cnt_r <= 5'h00;
          end else begin
            // A zero inside a short preamble starts the count again.
            pre_cnt_r <= 6'h00;
          end
        end
        S_HDR: begin
          hdr_r     <= hdr_word[11:0];
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r[3:0] == `PAN_HDR_LAST) begin
            // The last register index bit is in; decide on the frame.
            pre_cnt_r <= 6'h00;
            bit_cnt_r <= 5'h00;
            reg_sel_r <= hdr_word[4:0];
            is_read_r <= op_is_read(hdr_word[11:10]);
            // Frames for another address or with a bad start are dropped.
            if (hdr_word[12] && hdr_word[9:5] == PHY_ADDR &&
                (op_is_read(hdr_word[11:10]) ||
                 hdr_word[11:10] == `PAN_OP_WRITE)) begin
              state_r <= S_TA;
            end else begin
              // A dropped frame must be followed by a fresh full preamble.
              state_r <= S_PRE;
            end
          end
        end
        S_TA: begin
          if (is_read_r) begin
            // Second turnaround bit: the device drives zero and loads data.
            mgmt_data_oe  <= 1'b1;
            mgmt_data_out <= 1'b0;
            shift_r       <= rd_data;
            state_r       <= S_RD;
          end else if (bit_cnt_r != 5'h00) begin
            // Both turnaround bits of a write are ignored.
            bit_cnt_r <= 5'h00;
            state_r   <= S_WR;
          end else begin
            // First turnaround bit of a write; wait for the second.
            bit_cnt_r <= 5'h01;
          end
        end
        S_RD: begin
          if (bit_cnt_r == `PAN_DATA_BITS) begin
            // Release the line after the last data bit has been held.
            mgmt_data_oe  <= 1'b0;
            mgmt_data_out <= 1'b0;
            state_r       <= S_PRE;
          end else begin
            // Next data bit, most significant first.
            mgmt_data_out <= shift_r[15];
            shift_r       <= {shift_r[14:0], 1'b0};
            bit_cnt_r     <= bit_cnt_r + 5'h01;
          end
        end
        S_WR: begin
          shift_r   <= {shift_r[14:0], bit_in};
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == `PAN_DATA_BITS - 5'h01) begin
            // Sixteenth data bit; the commit logic below stores the word.
            state_r <= S_PRE;
          end
        end
        default: begin
          // Unused codes fall back to idle with the line released.
          state_r      <= S_PRE;
          mgmt_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // Write commit: fires on the edge that samples the last data bit.
  wire        wr_commit;  // Write of the addressed register completes now.
  wire [15:0] wr_word;    // Full write data including the final bit.

  assign wr_commit = mdc_rise && state_r == S_WR &&
                     bit_cnt_r == `PAN_DATA_BITS - 5'h01;
  assign wr_word   = {shift_r[14:0], bit_in};

  // Advertisement register. It doubles as the outgoing base page, so the
  // negotiation logic always sees exactly what software reads back.
  // Only next page, local fault and the four ability bits take writes;
  // reserved and T4 stay zero and the selector stays 00001.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      adv_page <= `PAN_ADV_RESET;
    end else if (wr_commit && reg_sel_r == `PAN_REG_ADVERTISE) begin
      adv_page <= (wr_word & `PAN_ADV_WR_MASK) | `PAN_ADV_FIXED;
    end
  end

  // Partner ability register. Software writes are ignored; only a received
  // base page changes it. Acknowledge, reserved and T4 are masked off so
  // a misbehaving partner cannot make them read one.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lp_r <= `PAN_LP_RESET;
    end else if (lp_page_valid) begin
      lp_r <= lp_page & `PAN_LP_KEEP_MASK;
    end
  end

endmodule // pan_regs

`default_nettype wire

// [test/pan_chk_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checks on the register block.
module pan_chk (
  input wire logic        clk,           // System clock.
  input wire logic        rst,           // Reset.
  input wire logic        mgmt_clk,      // Bus clock pin.
  input wire logic        mgmt_data_out, // Driven bit.
  input wire logic        mgmt_data_oe,  // Drive enable.
  input wire logic [15:0] adv_page       // Outgoing page.
);
  logic [3:0] low_r; // Cycles the bus clock stayed low.
  // A long low spell means no bus edge is pending, so adv_page may not change.
  always @(posedge clk or posedge rst) begin
    if (rst)
      low_r <= 4'h0;
    else if (mgmt_clk)
      low_r <= 4'h0;
    else if (low_r != 4'hF)
      low_r <= low_r + 4'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_SEL: assert property (adv_page[4:0] == 5'h01) else $error("bad selector");
  AST_T4: assert property (!adv_page[9]) else $error("T4 bit set");
  AST_RST: assert property ($fell(rst) |-> adv_page == 16'h01E1) else $error("bad reset page");
  AST_MASK: assert property (((adv_page ^ $past(adv_page)) & 16'h5E1F) == 16'h0000) else $error("fixed bit moved");
  AST_QUIET: assert property (low_r > 4'h6 |-> $stable(adv_page)) else $error("page moved idle");
  AST_TA: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_out) else $error("turnaround not low");
  AST_HOLD: assert property ($rose(mgmt_data_oe) |-> mgmt_data_oe[*8]) else $error("drive too short");
  AST_STEP: assert property (mgmt_data_oe && $changed(mgmt_data_out) |-> $past(mgmt_clk, 2)) else $error("bit off edge");
endmodule // pan_chk
bind pan_regs pan_chk i_chk (.clk(clk), .rst(rst), .mgmt_clk(mgmt_clk),
  .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe), .adv_page(adv_page));
`default_nettype wire

// [test/pan_sta.sv]
`timescale 1ns/1ps
`default_nettype none
// Station manager; its clock stands low between frames.
module pan_sta (
  input  wire logic clk,      // System clock.
  input  wire logic wire_lvl, // Resolved data line.
  output var  logic mgmt_clk, // Bus clock.
  output var  logic drv_oe,   // High while driving.
  output var  logic drv_val   // Driven bit.
);
  int half = 5; // Half period in clk cycles; larger is a slow manager.
  // Idle at time zero.
  initial begin
    mgmt_clk = 1'b0;
    drv_oe = 1'b0;
  end
  // One bit: drive while low, sample just before the rise.
  task automatic bit_cyc(input logic oe, input logic b, output logic s);
    @(negedge clk);
    mgmt_clk = 1'b0;
    drv_oe = oe;
    drv_val = b;
    repeat (half) @(negedge clk);
    s = wire_lvl;
    mgmt_clk = 1'b1;
    repeat (half - 1) @(negedge clk);
  endtask
  // Full frame; a read releases the line from the turnaround on.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [45:0] hdr;
    logic        wr;
    logic        s;
    hdr = {32'hFFFFFFFF, 2'b01, op, pa, ra};
    wr = (op != 2'b10);
    for (int i = 45; i >= 0; i--)
      bit_cyc(1'b1, hdr[i], s);
    bit_cyc(wr, 1'b1, s);
    bit_cyc(wr, 1'b0, ta);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wr, wd[i], s);
      rd[i] = s;
    end
    @(negedge clk);
    mgmt_clk = 1'b0;
    drv_oe = 1'b0;
    repeat (2 * half) @(negedge clk);
  endtask
endmodule // pan_sta
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pan_consts.vh"
module tb;
  logic        clk = 1'b0;           // System clock.
  logic        rst = 1'b1;           // Reset.
  logic [15:0] lp_page = 16'h0000;   // Partner page.
  logic        lp_page_valid = 1'b0; // Partner load strobe.
  logic        mgmt_clk, drv_oe, drv_val, mgmt_data_out, mgmt_data_oe, wire_lvl; // Bus pins.
  logic [15:0] adv_page, rd, d, adv_e, lp_e; // Pages and data.
  logic [15:0] ro_e [4];             // What refused writes must leave.
  logic [4:0]  ro_i [4] = '{5'h02, 5'h03, 5'h05, 5'h1F}; // Places not writable.
  logic [1:0]  bad_op [3] = '{2'b00, 2'b11, 2'b01};      // Refused opcodes, then a good one.
  logic [4:0]  bad_pa [3] = '{5'h01, 5'h01, 5'h07};      // Last one aims elsewhere.
  logic        ta;                   // Turnaround level.
  int          seed = 32'hCF67;
  int          n_errors = 0;
  int          comparisons = 0;
  always #12.5 clk = ~clk;
  // Pull-up holds the line high when nobody drives.
  assign wire_lvl = mgmt_data_oe ? mgmt_data_out : (drv_oe ? drv_val : 1'b1);
  pan_regs i_dut (.clk(clk), .rst(rst), .mgmt_clk(mgmt_clk), .mgmt_data_in(wire_lvl),
    .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe), .adv_page(adv_page),
    .lp_page(lp_page), .lp_page_valid(lp_page_valid));
  pan_sta i_sta (.clk(clk), .wire_lvl(wire_lvl), .mgmt_clk(mgmt_clk), .drv_oe(drv_oe), .drv_val(drv_val));
  // Only next page, fault and ability bits take a write.
  function automatic logic [15:0] adv_exp(input logic [15:0] v);
    return (v & 16'hA1E0) | 16'h0001;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    i_sta.frame(`PAN_OP_READ, 5'h01, ra, 16'h0000, rd, ta);
    check("register read", rd, exp);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang ends the run as a failure.
  initial begin
    #2500000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check("adv_page", adv_page, 16'h01E1);
    rd_chk(`PAN_REG_ID_LOW, 16'h1234);
    rd_chk(`PAN_REG_ID_HIGH, {6'h2A, 6'h11, 4'h3});
    rd_chk(`PAN_REG_ADVERTISE, 16'h01E1);
    rd_chk(`PAN_REG_PARTNER, 16'h0000);
    check("turnaround", {15'h0000, ta}, 16'h0000);
    // Corner values first, then random ones, at two bus speeds.
    for (int k = 0; k < 10; k++) begin
      d = (k == 0) ? 16'hFFFF : ((k == 1) ? 16'h0000 : 16'($random(seed)));
      i_sta.half = 5 + 4 * (k % 2);
      i_sta.frame(`PAN_OP_WRITE, 5'h01, `PAN_REG_ADVERTISE, d, rd, ta);
      adv_e = adv_exp(d);
      check("adv_page", adv_page, adv_e);
      rd_chk(`PAN_REG_ADVERTISE, adv_e);
      lp_page = (k == 0) ? 16'hFFFF : 16'($random(seed));
      lp_page_valid = 1'b1;
      lp_e = lp_page & 16'hA1FF;
      @(negedge clk);
      lp_page_valid = 1'b0;
      lp_page = ~lp_page;
      rd_chk(`PAN_REG_PARTNER, lp_e);
    end
    // Writes to read-only and unmapped places change nothing.
    ro_e = '{16'h1234, {6'h2A, 6'h11, 4'h3}, lp_e, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      i_sta.frame(`PAN_OP_WRITE, 5'h01, ro_i[k], 16'($random(seed)), rd, ta);
      rd_chk(ro_i[k], ro_e[k]);
    end
    for (int k = 0; k < 3; k++) begin
      i_sta.frame(bad_op[k], bad_pa[k], `PAN_REG_ADVERTISE, ~adv_e, rd, ta);
      check("adv_page", adv_page, adv_e);
    end
    i_sta.frame(`PAN_OP_READ, 5'h07, `PAN_REG_ADVERTISE, 16'h0000, rd, ta);
    check("foreign read", rd, 16'hFFFF);
    // A second reset in mid-run restores the defaults.
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check("adv_page", adv_page, 16'h01E1);
    rd_chk(`PAN_REG_PARTNER, 16'h0000);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
